// File: shared/sce_pkg.sv
// Constants for the serial configuration memory port.
// Assumes a 100 MHz system clock and a host-driven serial clock.
`default_nettype none

package sce_pkg;

  // Array shape
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS  = 64;

  // Opcodes and extension codes
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DIS  = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_EN   = 2'h3;

  // Bit counters and page limits
  localparam logic [4:0] HDR_LAST  = 5'h07;
  localparam logic [4:0] WORD_LAST = 5'h0F;
  localparam logic [3:0] PAGE_N    = 4'h8;
  localparam logic [6:0] FILL_LAST = 7'h3F;

  // Value of a cleared word
  localparam logic [15:0] ERASED = 16'hFFFF;

  // Self-timed programming time
  localparam int unsigned SYS_MHZ  = 100;
  localparam int unsigned PROG_NS  = 10000;
  localparam int unsigned PROG_CYC = (PROG_NS * SYS_MHZ + 999) / 1000;
  localparam logic [9:0]  PROG_CNT = 10'(PROG_CYC - 1);

  // Link side states
  typedef enum logic [4:0] {
    L_IDLE  = 5'h01,
    L_HDR   = 5'h02,
    L_WDATA = 5'h04,
    L_READ  = 5'h08,
    L_DONE  = 5'h10
  } sce_lst_t;

  // Programming engine states
  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_PROG = 3'h2,
    P_WAIT = 3'h4
  } sce_pst_t;

  // Kinds of programming operation
  typedef enum logic [2:0] {
    K_WR   = 3'h1,
    K_ER   = 3'h2,
    K_FILL = 3'h4
  } sce_kind_t;

endpackage : sce_pkg

`default_nettype wire

// File: hw/sce_sync.sv
// Two-flop level synchroniser, one per bit.
// Assumes inputs are levels that hold for several destination clocks.
`default_nettype none

module sce_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sce_sync_t;

  sce_sync_t r_q;
  sce_sync_t r_d;

  // First stage feeds only the second
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  assign q = r_q.s2;

endmodule : sce_sync

`default_nettype wire

// File: hw/sce_mem.sv
// 64 x 16 storage array with one write and one read port.
// Assumes writes and reads never target the array at the same time.
`default_nettype none

module sce_mem (
  // Write side
  input  wire logic        wclk,
  input  wire logic        we,
  input  wire logic [5:0]  waddr,
  input  wire logic [15:0] wdata,
  // Read side, registered output
  input  wire logic        rclk,
  input  wire logic [5:0]  raddr,
  output logic      [15:0] rdata
);

  logic [15:0] arr [sce_pkg::WORDS];

  // Self-timed programming path
  always_ff @(posedge wclk) begin
    if (we) begin
      arr[waddr] <= wdata;
    end
  end

  // Read every link edge; caller picks when
  always_ff @(posedge rclk) begin
    rdata <= arr[raddr];
  end

endmodule : sce_mem

`default_nettype wire

// File: hw/sce_port.sv
// Serial access port of a 1024-bit configuration memory.
// Assumes the host drives cs, sk and di; sk is the link clock.
//
// Functional notes
// - Array holds 64 words of 16 bits, six address bits.
// - Instruction is start bit, two opcode bits, six address bits.
// - Incoming bits are sampled on each rising link clock edge.
// - Data out floats except for read data or busy status.
// - Data out low while programming, high once ready.
// - Read gives a dummy zero, then the word MSB first.
// - Reading on continues with next words, wrapping to zero.
// - Deselect clears the instruction; reads must restart fully.
// - Write takes 16 data bits; programming starts at deselect.
// - Page write takes more words, low three address bits wrap.
// - Erase sets the addressed word to all ones.
// - Programming starts disabled; enable and disable commands.
// - While disabled, programming commands are ignored; reads work.
// - Fill-all writes one word everywhere, self-timed.
// - Rising download pin, still high, enters download mode.
// - Download entry waits until reset has ended.
// - Download streams dummy zero then words from address zero.
// - First deselect leaves download; re-entry needs a new edge.
// - Chip select is active high.
`default_nettype none

module sce_port (
  // System clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Serial link from host
  input  wire logic sk_clk,
  input  wire logic cs_in,
  input  wire logic di_in,
  // Serial data out, tri-state
  output logic      do_out,
  output logic      do_oe,
  // Download request pin
  input  wire logic download_trigger
);

  ////////////////////////////////////////////////////////////////////
  // Types

  typedef struct packed {
    sce_pkg::sce_lst_t  st;
    logic [7:0]         hsh;
    logic [4:0]         cnt;
    logic [5:0]         addr;
    logic [15:0]        wsh;
    logic [15:0]        osh;
    logic               rd_act;
    logic               rd_bit;
    logic               en;
    logic               tgl;
    sce_pkg::sce_kind_t pk;
    logic [5:0]         pa;
    logic [3:0]         pn;
    logic [2:0]         widx;
    logic [7:0][15:0]   pbuf;
  } sce_lnk_t;

  typedef struct packed {
    sce_pkg::sce_pst_t  ps;
    logic               cs_p;
    logic               dl_p;
    logic               dl;
    logic               busy;
    logic               stat;
    logic               ack;
    sce_pkg::sce_kind_t k;
    logic [5:0]         a;
    logic [6:0]         last;
    logic [6:0]         idx;
    logic [9:0]         tmr;
    logic [7:0][15:0]   wbuf;
    logic               dout;
    logic               doe;
  } sce_sys_t;

  ////////////////////////////////////////////////////////////////////
  // Declarations

  sce_lnk_t    l_q;
  sce_lnk_t    l_d;
  sce_sys_t    s_q;
  sce_sys_t    s_d;
  logic [7:0]  hdr;
  logic [15:0] wrd;
  logic [15:0] rdata;
  logic        mem_we;
  logic [5:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic        cs_s;
  logic        dl_s;
  logic        rd_act_s;
  logic        rd_bit_s;
  logic        tgl_s;
  logic        busy_l;
  logic        dl_l;
  logic        rst_l;
  logic        cs_fall;
  logic        dl_rise;
  logic        new_cmd;

  ////////////////////////////////////////////////////////////////////
  // Crossings

  // Pins and link state into the system domain
  sce_sync #(.W(5)) u_sync_sys (
    .clk (sys_clk),
    .d   ({cs_in, download_trigger, l_q.rd_act, l_q.rd_bit, l_q.tgl}),
    .q   ({cs_s, dl_s, rd_act_s, rd_bit_s, tgl_s})
  );

  // Busy, download and reset into the link domain
  sce_sync #(.W(3)) u_sync_lnk (
    .clk (sk_clk),
    .d   ({s_q.busy, s_q.dl, rst}),
    .q   ({busy_l, dl_l, rst_l})
  );

  // Storage; read port on the link clock, address one edge ahead
  sce_mem u_mem (
    .wclk  (sys_clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .rclk  (sk_clk),
    .raddr (l_d.addr),
    .rdata (rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Link domain: instruction decode and read shifter

  // One bit per rising edge; cs sampled like di
  always_comb begin
    l_d = l_q;
    hdr = {l_q.hsh[6:0], di_in};
    wrd = {l_q.wsh[14:0], di_in};
    unique case (l_q.st)
      sce_pkg::L_IDLE: begin
        // Busy: stay deaf until programming ends
        if (cs_in && !busy_l) begin
          if (dl_l) begin
            l_d.st     = sce_pkg::L_READ;
            l_d.addr   = '0;
            l_d.rd_act = 1'h1;
            l_d.rd_bit = 1'h0;
            l_d.cnt    = '0;
          end else if (di_in) begin
            l_d.st  = sce_pkg::L_HDR;
            l_d.cnt = '0;
          end
        end
      end
      sce_pkg::L_HDR: begin
        l_d.hsh = hdr;
        l_d.cnt = l_q.cnt + 5'h01;
        if (l_q.cnt == sce_pkg::HDR_LAST) begin
          l_d.st   = sce_pkg::L_DONE;
          l_d.cnt  = '0;
          l_d.addr = hdr[5:0];
          unique case (hdr[7:6])
            sce_pkg::OP_READ: begin
              l_d.st     = sce_pkg::L_READ;
              l_d.rd_act = 1'h1;
              l_d.rd_bit = 1'h0;
            end
            sce_pkg::OP_ERASE: begin
              if (l_q.en) begin
                l_d.pk  = sce_pkg::K_ER;
                l_d.pa  = hdr[5:0];
                l_d.tgl = ~l_q.tgl;
              end
            end
            sce_pkg::OP_WRITE: begin
              if (l_q.en) begin
                l_d.st   = sce_pkg::L_WDATA;
                l_d.pk   = sce_pkg::K_WR;
                l_d.pa   = hdr[5:0];
                l_d.pn   = '0;
                l_d.widx = '0;
              end
            end
            sce_pkg::OP_EXT: begin
              case (hdr[5:4])
                sce_pkg::EXT_EN:  l_d.en = 1'h1;
                sce_pkg::EXT_DIS: l_d.en = 1'h0;
                sce_pkg::EXT_FILL: begin
                  if (l_q.en) begin
                    l_d.st   = sce_pkg::L_WDATA;
                    l_d.pk   = sce_pkg::K_FILL;
                    l_d.pn   = '0;
                    l_d.widx = '0;
                  end
                end
                default: l_d.st = sce_pkg::L_DONE;
              endcase
            end
          endcase
        end
      end
      sce_pkg::L_WDATA: begin
        l_d.wsh = wrd;
        l_d.cnt = l_q.cnt + 5'h01;
        // Each further word goes to the next slot of the page
        if (l_q.cnt == sce_pkg::WORD_LAST) begin
          l_d.cnt             = '0;
          l_d.pbuf[l_q.widx]  = wrd;
          l_d.widx            = l_q.widx + 3'h1;
          if (l_q.pn != sce_pkg::PAGE_N) begin
            l_d.pn = l_q.pn + 4'h1;
          end
          // First whole word makes the command pending
          if (l_q.pn == 4'h0) begin
            l_d.tgl = ~l_q.tgl;
          end
          if (l_q.pk == sce_pkg::K_FILL) begin
            l_d.st = sce_pkg::L_DONE;
          end
        end
      end
      sce_pkg::L_READ: begin
        // Load edge also moves the array read one word on
        if (l_q.cnt == 5'h00) begin
          l_d.osh    = {rdata[14:0], 1'h0};
          l_d.rd_bit = rdata[15];
          l_d.cnt    = sce_pkg::WORD_LAST;
          l_d.addr   = l_q.addr + 6'h01;
        end else begin
          l_d.rd_bit = l_q.osh[15];
          l_d.osh    = {l_q.osh[14:0], 1'h0};
          l_d.cnt    = l_q.cnt - 5'h01;
        end
      end
      sce_pkg::L_DONE: begin
        l_d.st = sce_pkg::L_DONE;
      end
    endcase
    // Deselect drops any half-done instruction
    if (!cs_in) begin
      l_d.st     = sce_pkg::L_IDLE;
      l_d.rd_act = 1'h0;
      l_d.cnt    = '0;
    end
    // Link reset also drops the program enable
    if (rst_l) begin
      l_d    = '0;
      l_d.st = sce_pkg::L_IDLE;
      l_d.pk = sce_pkg::K_WR;
    end
  end

  always_ff @(posedge sk_clk) begin
    l_q <= l_d;
  end

  ////////////////////////////////////////////////////////////////////
  // System domain: download mode, programming, data out

  assign cs_fall = s_q.cs_p && !cs_s;
  assign dl_rise = dl_s && !s_q.dl_p;
  assign new_cmd = tgl_s != s_q.ack;

  // Array write port follows the engine state
  always_comb begin
    mem_we = s_q.ps == sce_pkg::P_PROG;
    unique case (s_q.k)
      sce_pkg::K_WR: begin
        mem_waddr = {s_q.a[5:3], s_q.a[2:0] + s_q.idx[2:0]};
        mem_wdata = s_q.wbuf[s_q.idx[2:0]];
      end
      sce_pkg::K_ER: begin
        mem_waddr = s_q.a;
        mem_wdata = sce_pkg::ERASED;
      end
      default: begin
        mem_waddr = s_q.idx[5:0];
        mem_wdata = s_q.wbuf[0];
      end
    endcase
  end

  // Field copy is safe: link is held still while cs is low
  always_comb begin
    s_d      = s_q;
    s_d.cs_p = cs_s;
    s_d.dl_p = dl_s;
    // Entry beats exit when both land together
    if (cs_fall) begin
      s_d.dl = 1'h0;
    end
    // Reset clears dl_p, so a pin already high counts as an edge
    if (dl_rise) begin
      s_d.dl = 1'h1;
    end
    if (cs_fall && !s_q.busy) begin
      s_d.stat = 1'h0;
    end
    unique case (s_q.ps)
      sce_pkg::P_IDLE: begin
        if (cs_fall && new_cmd) begin
          s_d.ack  = tgl_s;
          s_d.busy = 1'h1;
          s_d.stat = 1'h1;
          s_d.k    = l_q.pk;
          s_d.a    = l_q.pa;
          s_d.wbuf = l_q.pbuf;
          s_d.idx  = '0;
          s_d.ps   = sce_pkg::P_PROG;
          unique case (l_q.pk)
            sce_pkg::K_WR:   s_d.last = {3'h0, l_q.pn} - 7'h01;
            sce_pkg::K_ER:   s_d.last = '0;
            default:         s_d.last = sce_pkg::FILL_LAST;
          endcase
        end
      end
      sce_pkg::P_PROG: begin
        s_d.idx = s_q.idx + 7'h01;
        if (s_q.idx == s_q.last) begin
          s_d.ps  = sce_pkg::P_WAIT;
          s_d.tmr = sce_pkg::PROG_CNT;
        end
      end
      default: begin
        // Self-timed wait; no link clock needed
        if (s_q.tmr == 10'h000) begin
          s_d.busy = 1'h0;
          s_d.ps   = sce_pkg::P_IDLE;
        end else begin
          s_d.tmr = s_q.tmr - 10'h001;
        end
      end
    endcase
    // Busy status outranks everything while selected
    s_d.doe  = 1'h0;
    s_d.dout = 1'h0;
    if (cs_s) begin
      if (s_q.busy) begin
        s_d.doe = 1'h1;
      end else if (rd_act_s) begin
        s_d.doe  = 1'h1;
        s_d.dout = rd_bit_s;
      end else if (s_q.stat) begin
        s_d.doe  = 1'h1;
        s_d.dout = 1'h1;
      end
    end
    if (rst) begin
      s_d    = '0;
      s_d.ps = sce_pkg::P_IDLE;
      s_d.k  = sce_pkg::K_WR;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // Pin drivers straight from flops
  assign do_out = s_q.dout;
  assign do_oe  = s_q.doe;

  ////////////////////////////////////////////////////////////////////
  // Checks, system domain

  sequence s_take;
    s_q.ps == sce_pkg::P_IDLE && cs_fall && new_cmd;
  endsequence

  sequence s_prog_on;
    s_q.busy && s_q.ps == sce_pkg::P_PROG;
  endsequence

  property p_start;
    @(posedge sys_clk) disable iff (rst)
    s_take |=> s_prog_on;
  endproperty
  a_start: assert property (p_start)
    else $error("programming did not start at deselect");

  property p_busy_low;
    @(posedge sys_clk) disable iff (rst)
    s_q.busy && cs_s |=> s_q.doe && !s_q.dout;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy not shown low on data out");

  property p_ready_high;
    @(posedge sys_clk) disable iff (rst)
    cs_s && !s_q.busy && !rd_act_s && s_q.stat |=> s_q.doe && s_q.dout;
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("ready not shown high on data out");

  property p_float;
    @(posedge sys_clk) disable iff (rst)
    !cs_s |=> !s_q.doe;
  endproperty
  a_float: assert property (p_float)
    else $error("data out driven while deselected");

  property p_erase_ones;
    @(posedge sys_clk) disable iff (rst)
    mem_we && s_q.k == sce_pkg::K_ER |->
      mem_wdata == sce_pkg::ERASED && mem_waddr == s_q.a;
  endproperty
  a_erase_ones: assert property (p_erase_ones)
    else $error("erase did not write ones");

  property p_fill_run;
    @(posedge sys_clk) disable iff (rst)
    $rose(mem_we) && s_q.k == sce_pkg::K_FILL |-> mem_we [*8];
  endproperty
  a_fill_run: assert property (p_fill_run)
    else $error("fill-all stopped early");

  property p_deaf;
    @(posedge sys_clk) disable iff (rst)
    s_q.ps != sce_pkg::P_IDLE |=> $stable(s_q.ack);
  endproperty
  a_deaf: assert property (p_deaf)
    else $error("command taken while programming");

  property p_dl_in;
    @(posedge sys_clk) disable iff (rst)
    dl_rise |=> s_q.dl;
  endproperty
  a_dl_in: assert property (p_dl_in)
    else $error("download mode not entered");

  property p_dl_out;
    @(posedge sys_clk) disable iff (rst)
    cs_fall && !dl_rise |=> !s_q.dl;
  endproperty
  a_dl_out: assert property (p_dl_out)
    else $error("download mode not left at deselect");

  ////////////////////////////////////////////////////////////////////
  // Checks, link domain

  property p_dummy;
    @(posedge sk_clk) disable iff (rst_l)
    cs_in && l_q.st == sce_pkg::L_HDR && l_q.cnt == sce_pkg::HDR_LAST
      && hdr[7:6] == sce_pkg::OP_READ
      |=> l_q.rd_act && !l_q.rd_bit && l_q.cnt == 5'h00;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("read did not open with a dummy zero");

  property p_clear;
    @(posedge sk_clk) disable iff (rst_l)
    !cs_in |=> l_q.st == sce_pkg::L_IDLE && !l_q.rd_act;
  endproperty
  a_clear: assert property (p_clear)
    else $error("instruction not cleared on deselect");

  property p_wrap;
    @(posedge sk_clk) disable iff (rst_l)
    cs_in && l_q.st == sce_pkg::L_READ && l_q.cnt == 5'h00
      && l_q.addr == 6'h3F |=> l_q.addr == 6'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("read address did not wrap to zero");

  property p_locked;
    @(posedge sk_clk) disable iff (rst_l)
    !l_q.en && l_q.st == sce_pkg::L_HDR |=> $stable(l_q.tgl);
  endproperty
  a_locked: assert property (p_locked)
    else $error("programming accepted while disabled");

endmodule : sce_port

`default_nettype wire

// File: testbench/sce_host.sv
// Host model for the three-wire link: clocks, selects, shifts, polls.
// Assumes data out floats whenever the port's enable is low.
`default_nettype none

module sce_host (
  // Link to the port
  output logic      sk_clk,
  output logic      cs_in,
  output logic      di_in,
  // Data out from the port
  input  wire logic do_out,
  input  wire logic do_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  wire do_w;

  // Resolved pin; a floating pin reads as z
  assign do_w = do_oe ? do_out : 1'bz;

  // Link clock, select and data all start low
  initial begin
    sk_clk = 1'b0;
    cs_in  = 1'b0;
    di_in  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 30 ns period; data changes while the clock is low
  task automatic tick(input logic d);
    di_in = d;
    #15 sk_clk = 1'b1;
    #15 sk_clk = 1'b0;
  endtask : tick

  // Deselected clocks clear the link state between frames
  task automatic idle(input int n);
    cs_in = 1'b0;
    repeat (n) tick(1'b0);
  endtask : idle

  // Select and shift n bits, most significant first
  task automatic send(input logic [40:0] v, input int n);
    cs_in = 1'b1;
    for (int i = n - 1; i >= 0; i--) tick(v[i]);
  endtask : send

  // Sample each bit a half period after the following rise
  task automatic shift(input int n, output logic [16:0] q);
    q = '0;
    repeat (n) begin
      tick(1'b0);
      q = {q[15:0], do_w};
    end
  endtask : shift

  // Select without clocks and watch status; bounded wait for ready
  task automatic poll(input int lim, output logic b, output logic r);
    cs_in = 1'b1;
    #60 b = do_w;
    r = 1'b0;
    for (int i = 0; i < lim && r !== 1'b1; i++) #10 r = do_w;
    idle(3);
  endtask : poll

endmodule : sce_host

`default_nettype wire

// File: testbench/serial_config_eeprom_port_tb.sv
// Self-checking bench for the serial configuration memory port.
// Assumes the host model drives the link; bench drives reset and pin.
`default_nettype none

module serial_config_eeprom_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rst;
  logic        download_trigger;
  wire         sk_clk;
  wire         cs_in;
  wire         di_in;
  wire         do_out;
  wire         do_oe;
  int          fail_count;
  int          n_compared;
  logic [16:0] q;
  logic        b;
  logic        r;

  sce_port dut (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .sk_clk           (sk_clk),
    .cs_in            (cs_in),
    .di_in            (di_in),
    .do_out           (do_out),
    .do_oe            (do_oe),
    .download_trigger (download_trigger)
  );

  sce_host host (
    .sk_clk (sk_clk),
    .cs_in  (cs_in),
    .di_in  (di_in),
    .do_out (do_out),
    .do_oe  (do_oe)
  );

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [16:0] seen,
                     input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Hold select low past 250 ns, then poll; a status mismatch ends the run
  task automatic prog(input int lim, input logic eb, input logic er);
    host.idle(9);
    host.poll(lim, b, r);
    chk("status", {b, r}, {eb, er});
    if ({b, r} !== {eb, er}) give_verdict();
  endtask : prog

  task automatic rd(input logic [5:0] a);
    host.send({1'b1, sce_pkg::OP_READ, a}, 9);
    host.shift(17, q);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Erase command refused before any enable
  task automatic t_locked();
    host.send({1'b1, sce_pkg::OP_ERASE, 6'h3F}, 9);
    prog(200, 1'bz, 1'bz);
  endtask : t_locked

  // Enable, fill every word, write the top word, erase word zero
  task automatic t_fill_write();
    host.send({1'b1, sce_pkg::OP_EXT, sce_pkg::EXT_EN, 4'h0}, 9);
    host.idle(3);
    host.send({1'b1, sce_pkg::OP_EXT, sce_pkg::EXT_FILL, 4'h0,
               16'h1234}, 25);
    prog(3000, 1'b0, 1'b1);
    host.send({1'b1, sce_pkg::OP_WRITE, 6'h3F, 16'hA5C3}, 25);
    prog(3000, 1'b0, 1'b1);
    host.send({1'b1, sce_pkg::OP_ERASE, 6'h00}, 9);
    host.idle(9);
    rd(6'h3F);
    chk("busy_read", q, 17'h00000);
    host.idle(3);
    prog(3000, 1'b0, 1'b1);
  endtask : t_fill_write

  // Continuous read across the top of the array
  task automatic t_cont_read();
    rd(6'h3F);
    chk("read_3F", q, {1'b0, 16'hA5C3});
    host.shift(16, q);
    chk("wrap_00", q, 17'h0FFFF);
    host.shift(16, q);
    chk("next_01", q, 17'h01234);
    host.idle(3);
  endtask : t_cont_read

  // Clocks without a start bit after a deselect leave data out floating
  task automatic t_fresh();
    host.send(41'h0, 9);
    host.shift(17, q);
    chk("no_start", q, {17{1'bz}});
    host.idle(3);
  endtask : t_fresh

  // Nine words from 0E: slot pointer wraps 0F to 08, ninth hits 0E again
  task automatic t_page();
    logic [15:0] e;
    host.send({1'b1, sce_pkg::OP_WRITE, 6'h0E}, 9);
    for (int i = 0; i < 9; i++) host.send(41'(16'h1000 + i), 16);
    prog(12000, 1'b0, 1'b1);
    for (int j = 0; j < 8; j++) begin
      e = (j == 6) ? 16'h1008 : 16'h1000 + 16'((j + 2) % 8);
      if (j == 0) begin
        rd(6'h08);
      end else begin
        host.shift(16, q);
      end
      chk("page", q, {1'b0, e});
    end
    host.idle(3);
  endtask : t_page

  // Disable refuses a write; reads still work
  task automatic t_disable();
    host.send({1'b1, sce_pkg::OP_EXT, sce_pkg::EXT_DIS, 4'h0}, 9);
    host.idle(3);
    host.send({1'b1, sce_pkg::OP_WRITE, 6'h3F, 16'h0000}, 25);
    prog(200, 1'bz, 1'bz);
    rd(6'h3F);
    chk("kept_3F", q, {1'b0, 16'hA5C3});
    host.idle(3);
  endtask : t_disable

  // Pin edge streams from word zero; the first deselect ends the mode
  task automatic t_download();
    @(negedge sys_clk) download_trigger = 1'b1;
    repeat (6) @(negedge sys_clk);
    // Link side sees the mode only after two of its own clock edges
    host.idle(3);
    host.send(41'h0, 1);
    host.shift(17, q);
    chk("dl_w0", q, 17'h0FFFF);
    host.shift(16, q);
    chk("dl_w1", q, 17'h01234);
    host.idle(4);
    host.send(41'h0, 1);
    host.shift(17, q);
    chk("dl_left", q, {17{1'bz}});
    host.idle(4);
  endtask : t_download

  // Mid-run reset with the pin still high: entry after release, locked
  task automatic t_reset_dl();
    @(negedge sys_clk) rst = 1'b1;
    host.idle(4);
    @(negedge sys_clk) rst = 1'b0;
    host.idle(4);
    host.send(41'h0, 1);
    host.shift(17, q);
    chk("rst_dl_w0", q, 17'h0FFFF);
    host.idle(4);
    host.send({1'b1, sce_pkg::OP_ERASE, 6'h3F}, 9);
    prog(200, 1'bz, 1'bz);
  endtask : t_reset_dl

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is stretched so the link clock sees it too
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst = 1'b1;
    download_trigger = 1'b0;
    #3;
    host.idle(4);
    @(negedge sys_clk) rst = 1'b0;
    host.idle(4);
    chk("oe_reset", 17'(do_oe), 17'h0);
    t_locked();
    t_fill_write();
    t_cont_read();
    t_fresh();
    t_page();
    t_disable();
    t_download();
    t_reset_dl();
    give_verdict();
  end

endmodule : serial_config_eeprom_port_tb

`default_nettype wire
